//--- smc_pkg.sv
// standby mode controller package: mode codes, request/wake carriers, reset stretch
// assumes a single 20 MHz core clock domain
package smc_pkg;

    localparam int unsigned CLK_HZ = 20_000_000;
    // reset stretch after any reset source falls away, in nanoseconds
    localparam int unsigned RST_STRETCH_NS = 1000;
    localparam int unsigned RST_STRETCH_CYC =
        (RST_STRETCH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [7:0] RST_STRETCH_VAL = 8'(RST_STRETCH_CYC);

    // standby request codes from the processor core
    localparam logic [1:0] REQ_NONE = 2'h0;
    localparam logic [1:0] REQ_IDLE = 2'h1;
    localparam logic [1:0] REQ_DEEP_HOLD = 2'h2;
    localparam logic [1:0] REQ_XTAL_HOLD = 2'h3;

    typedef enum logic [1:0] {
        SMC_RUN = 2'b00,
        SMC_IDLE = 2'b01,
        SMC_DEEP = 2'b11,
        SMC_XTAL = 2'b10
    } smc_state_type;

    // wake and interrupt sources
    typedef struct packed {
        logic ext_irq_pin_a;
        logic ext_irq_pin_b;
        logic ext_irq_pin_c;
        logic ext_irq_pin_e;
        logic ext_irq_pin_f;
        logic port0_irq;
        logic base_timer_irq;
        logic usb_bus_active_irq;
        logic other_irq;
    } smc_wake_type;

    // oscillator and clock-gate enables
    typedef struct packed {
        logic pll_en;
        logic ceramic_oscillator_en;
        logic rc_osc_en;
        logic xtal_osc_en;
        logic cpu_clk_en;
        logic periph_clk_en;
        logic base_timer_clk_en;
    } smc_clk_type;

endpackage : smc_pkg

//--- smc_standby_ctrl.sv
// standby and reset sequencer: idle, deep hold and crystal hold modes
// assumes wake sources from pins are already synchronised; irqs from peripherals are on core_clk_i
// a standby request is taken only in run while no reset source is active
module smc_standby_ctrl (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic reset_pin_n_i,
    input wire logic watchdog_rst_i,
    input wire logic low_voltage_detector_i,
    input wire logic low_voltage_enable_i,
    input wire logic por_active_i,
    input wire logic [1:0] standby_req_i,
    input wire logic standby_req_valid_i,
    input wire logic level_detect_a_i,
    input wire logic level_detect_b_i,
    input wire smc_pkg::smc_wake_type wake_i,
    input wire logic [6:0] run_clk_en_i,
    output logic sys_rst_o,
    output logic cpu_halted_o,
    output logic resume_irq_o,
    output smc_pkg::smc_clk_type clk_en_o,
    output logic [1:0] mode_o
);

    smc_pkg::smc_state_type state_reg;
    smc_pkg::smc_state_type state_next;
    logic [1:0] rpin_sync_reg;
    logic [1:0] lv_sync_reg;
    logic por_seen_reg;
    logic [7:0] stretch_reg;
    logic xtal_frozen_reg;
    logic resume_reg;
    smc_pkg::smc_clk_type clk_reg;
    smc_pkg::smc_clk_type run_clk;
    smc_pkg::smc_clk_type clk_next;
    logic pin_rst;
    logic por_rst;
    logic lv_rst;
    logic rst_src;
    logic pin_a_wake;
    logic pin_b_wake;
    logic irq_wake;
    logic any_irq;
    logic hold_wake;
    logic xtal_wake;

    assign run_clk = smc_pkg::smc_clk_type'(run_clk_en_i);

    // reset pin is asynchronous; two flops before use
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rpin_sync_reg <= 2'h3;
        end else begin
            rpin_sync_reg <= {rpin_sync_reg[0], reset_pin_n_i};
        end
    end

    // the detector is asynchronous too and may chatter near its threshold
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lv_sync_reg <= 2'h0;
        end else begin
            lv_sync_reg <= {lv_sync_reg[0], low_voltage_detector_i};
        end
    end

    // power-on source is honoured once; later pulses are ignored
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            por_seen_reg <= 1'b0;
        end else if (!por_active_i) begin
            por_seen_reg <= 1'b1;
        end
    end

    // power-on source is not synchronised: it only matters while the clock starts
    assign pin_rst = !rpin_sync_reg[1];
    assign por_rst = por_active_i && !por_seen_reg;
    assign lv_rst = low_voltage_enable_i && lv_sync_reg[1];
    assign rst_src = pin_rst || watchdog_rst_i || por_rst || lv_rst;

    // edge-mode requests on pins a and b never wake a hold mode
    assign pin_a_wake = wake_i.ext_irq_pin_a && level_detect_a_i;
    assign pin_b_wake = wake_i.ext_irq_pin_b && level_detect_b_i;
    assign hold_wake = pin_a_wake || pin_b_wake
        || wake_i.ext_irq_pin_c || wake_i.ext_irq_pin_e || wake_i.ext_irq_pin_f
        || wake_i.port0_irq || wake_i.usb_bus_active_irq;
    assign xtal_wake = hold_wake || wake_i.base_timer_irq;
    assign any_irq = |wake_i;

    // reset stretched so the core sees a clean restart; a settling monitor is traded
    // for a fixed count, so very slow supplies need a longer stretch
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stretch_reg <= smc_pkg::RST_STRETCH_VAL;
        end else if (rst_src) begin
            stretch_reg <= smc_pkg::RST_STRETCH_VAL;
        end else if (stretch_reg != 8'h00) begin
            stretch_reg <= stretch_reg - 8'h01;
        end
    end

    // requests count only in run; the hold modes leave through wakes alone
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            smc_pkg::SMC_RUN: begin
                if (standby_req_valid_i) begin
                    unique case (standby_req_i)
                        smc_pkg::REQ_IDLE: state_next = smc_pkg::SMC_IDLE;
                        smc_pkg::REQ_DEEP_HOLD: state_next = smc_pkg::SMC_DEEP;
                        smc_pkg::REQ_XTAL_HOLD: state_next = smc_pkg::SMC_XTAL;
                        smc_pkg::REQ_NONE: state_next = smc_pkg::SMC_RUN;
                    endcase
                end
            end
            smc_pkg::SMC_IDLE: if (any_irq) state_next = smc_pkg::SMC_RUN;
            smc_pkg::SMC_DEEP: if (hold_wake) state_next = smc_pkg::SMC_RUN;
            smc_pkg::SMC_XTAL: if (xtal_wake) state_next = smc_pkg::SMC_RUN;
        endcase
    end

    // any reset source forces run state; restart comes from sys_rst_o
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= smc_pkg::SMC_RUN;
        end else if (rst_src) begin
            state_reg <= smc_pkg::SMC_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // only an interrupt wake resumes; a reset wake restarts from scratch instead
    assign irq_wake = !rst_src && state_reg != smc_pkg::SMC_RUN
        && state_next == smc_pkg::SMC_RUN;

    // interrupt wake flags the core to resume and service the request
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            resume_reg <= 1'b0;
        end else begin
            resume_reg <= irq_wake;
        end
    end

    // crystal state captured at crystal hold entry and held throughout
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            xtal_frozen_reg <= 1'b0;
        end else if (state_reg == smc_pkg::SMC_RUN) begin
            xtal_frozen_reg <= run_clk.xtal_osc_en;
        end
    end

    // enables for the mode about to be entered; low-speed rc is an output here too,
    // taken from run_clk in run and idle and cleared in both hold modes
    always_comb begin
        clk_next = run_clk;
        unique case (state_next)
            smc_pkg::SMC_RUN: begin
                clk_next = run_clk;
            end
            smc_pkg::SMC_IDLE: begin
                // idle gates only the cpu; oscillators stay as they were
                clk_next = run_clk;
                clk_next.cpu_clk_en = 1'b0;
            end
            smc_pkg::SMC_DEEP: begin
                clk_next = '0;
            end
            smc_pkg::SMC_XTAL: begin
                clk_next = '0;
                if (state_reg == smc_pkg::SMC_XTAL) begin
                    clk_next.xtal_osc_en = xtal_frozen_reg;
                end else begin
                    clk_next.xtal_osc_en = run_clk.xtal_osc_en;
                end
                clk_next.base_timer_clk_en = 1'b1;
            end
        endcase
        // a reset source hands control straight back to the run enables
        if (rst_src) begin
            clk_next = run_clk;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            clk_reg <= '0;
        end else begin
            clk_reg <= clk_next;
        end
    end

    assign sys_rst_o = rst_src || (stretch_reg != 8'h00);
    assign cpu_halted_o = (state_reg != smc_pkg::SMC_RUN);
    assign resume_irq_o = resume_reg;
    assign clk_en_o = clk_reg;
    assign mode_o = state_reg;

endmodule : smc_standby_ctrl

//--- smc_standby_ctrl_sva.sv
// port-level checks for the standby controller
// assumes one core clock domain and the async active-low reset
module smc_standby_ctrl_sva (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic level_detect_a_i,
    input wire smc_pkg::smc_wake_type wake_i,
    input wire logic sys_rst_o,
    input wire logic resume_irq_o,
    input wire smc_pkg::smc_clk_type clk_en_o,
    input wire logic [1:0] mode_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    property p_idle_cpu; mode_o == 2'h1 |-> !clk_en_o.cpu_clk_en; endproperty
    a_idle_cpu: assert property (p_idle_cpu) else $error("cpu clock on in idle");
    property p_deep_clk; mode_o == 2'h3 |-> clk_en_o == 7'h00; endproperty
    a_deep_clk: assert property (p_deep_clk) else $error("clock on in deep hold");
    property p_xtal_clk;
        mode_o == 2'h2 |-> clk_en_o.base_timer_clk_en && clk_en_o[6:4] == 3'h0 && !clk_en_o[2];
    endproperty
    a_xtal_clk: assert property (p_xtal_clk) else $error("crystal hold clocks wrong");
    property p_xtal_keep; mode_o == 2'h2 && $past(mode_o) == 2'h2 |-> $stable(clk_en_o[3]); endproperty
    a_xtal_keep: assert property (p_xtal_keep) else $error("crystal enable moved");
    property p_edge_pin;
        mode_o[1] && !sys_rst_o && wake_i == 9'h100 && !level_detect_a_i
            |=> mode_o == $past(mode_o) || sys_rst_o;
    endproperty
    a_edge_pin: assert property (p_edge_pin) else $error("edge pin woke hold");
    property p_bt_wake; mode_o == 2'h2 && wake_i.base_timer_irq |=> mode_o == 2'h0; endproperty
    a_bt_wake: assert property (p_bt_wake) else $error("base timer did not wake");
    property p_port0; mode_o == 2'h3 && wake_i.port0_irq |=> mode_o == 2'h0; endproperty
    a_port0: assert property (p_port0) else $error("port0 did not wake");
    property p_idle_wake; mode_o == 2'h1 && wake_i != 9'h000 |=> mode_o == 2'h0; endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("irq did not end idle");
    property p_resume;
        $past(mode_o) != 2'h0 && mode_o == 2'h0 && !sys_rst_o |-> resume_irq_o ##1 !resume_irq_o;
    endproperty
    a_resume: assert property (p_resume) else $error("resume pulse wrong");
endmodule : smc_standby_ctrl_sva
bind smc_standby_ctrl smc_standby_ctrl_sva u_sva (.core_clk_i, .rstn_i, .level_detect_a_i,
    .wake_i, .sys_rst_o, .resume_irq_o, .clk_en_o, .mode_o);

//--- smc_irq_model.sv
// interrupt sources: a request stays pending until serviced or reset
// assumes set pulses arrive on core_clk_i
module smc_irq_model (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic [8:0] set_i,
    input wire logic resume_irq_i,
    input wire logic sys_rst_i,
    output smc_pkg::smc_wake_type wake_o
);
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i || sys_rst_i || resume_irq_i) begin
            wake_o <= 9'h000;
        end else begin
            wake_o <= wake_o | set_i;
        end
    end
endmodule : smc_irq_model

//--- tb_top.sv
// self-checking bench for the standby controller
// assumes the package, design, partner and bound checker are compiled first
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i = 1'b0, rstn_i = 1'b0, reset_pin_n_i = 1'b1, watchdog_rst_i = 1'b0;
    logic low_voltage_detector_i = 1'b0, low_voltage_enable_i = 1'b1, por_active_i = 1'b1;
    logic standby_req_valid_i = 1'b0, level_detect_a_i = 1'b0, level_detect_b_i = 1'b0;
    logic [1:0] standby_req_i = 2'h0, prev = 2'h0, code, mode_o, q_exp[$];
    logic [6:0] run_clk_en_i = 7'h7F;
    logic [8:0] set_w = 9'h000;
    logic [7:0] rnd = 8'h13;
    logic sys_rst_o, cpu_halted_o, resume_irq_o;
    smc_pkg::smc_clk_type clk_en_o;
    smc_pkg::smc_wake_type wake;
    int n_mismatch = 0, n_compared = 0, cyc = 0;
    smc_standby_ctrl DUT (.core_clk_i, .rstn_i, .reset_pin_n_i, .watchdog_rst_i,
        .low_voltage_detector_i, .low_voltage_enable_i, .por_active_i, .standby_req_i,
        .standby_req_valid_i, .level_detect_a_i, .level_detect_b_i, .wake_i(wake),
        .run_clk_en_i, .sys_rst_o, .cpu_halted_o, .resume_irq_o, .clk_en_o, .mode_o);
    smc_irq_model u_src (.core_clk_i, .rstn_i, .set_i(set_w), .resume_irq_i(resume_irq_o),
        .sys_rst_i(sys_rst_o), .wake_o(wake));
    initial forever #25 core_clk_i = ~core_clk_i;
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    task automatic chk(input logic [8:0] seen, input logic [8:0] want);
        n_compared++;
        if (seen !== want) begin
            n_mismatch++;
            $display("MISMATCH t=%0t saw %h want %h", $time, seen, want);
        end
    endtask : chk
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize
    // ign is tried first and must not wake; w then must
    task automatic sleep(input logic [1:0] c, input logic [8:0] ign, input logic [8:0] w);
        @(posedge core_clk_i);
        standby_req_i <= c;
        standby_req_valid_i <= 1'b1;
        level_detect_a_i <= 1'b0;
        q_exp.push_back({c[1], c[0] ^ c[1]});
        @(posedge core_clk_i);
        standby_req_valid_i <= 1'b0;
        set_w <= ign;
        @(posedge core_clk_i);
        set_w <= 9'h000;
        repeat (4) @(posedge core_clk_i);
        level_detect_a_i <= 1'b1;
        set_w <= w;
        q_exp.push_back(2'h0);
        @(posedge core_clk_i);
        set_w <= 9'h000;
        repeat (6) @(posedge core_clk_i);
        $display("test done: request %h", c);
    endtask : sleep
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 4000) begin
            n_mismatch++;
            summarize();
        end
    end
    initial forever begin
        @(posedge core_clk_i);
        #1;
        if (mode_o !== prev) begin
            prev = mode_o;
            chk(mode_o, q_exp.size() > 0 ? q_exp.pop_front() : ~mode_o);
            chk(9'(cpu_halted_o), 9'(mode_o != 2'h0));
            if (mode_o == 2'h1) begin
                chk(9'(clk_en_o), 9'h07B);
            end
        end
    end
    initial begin
        repeat (2) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        por_active_i <= 1'b0;
        repeat (30) @(posedge core_clk_i);
        por_active_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        #1 chk(2'(sys_rst_o), 2'h0);
        sleep(smc_pkg::REQ_IDLE, 9'h000, 9'h001);
        sleep(smc_pkg::REQ_DEEP_HOLD, 9'h004, 9'h008);
        sleep(smc_pkg::REQ_DEEP_HOLD, 9'h100, 9'h100);
        sleep(smc_pkg::REQ_XTAL_HOLD, 9'h080, 9'h004);
        repeat (6) begin
            rnd = lfsr(rnd);
            code = 2'(rnd % 3) + 2'h1;
            sleep(code, 9'h000, rnd[3] ? 9'h008 : (rnd[4] ? 9'h020 : 9'h002));
        end
        @(posedge core_clk_i);
        standby_req_i <= smc_pkg::REQ_DEEP_HOLD;
        standby_req_valid_i <= 1'b1;
        q_exp.push_back(2'h3);
        @(posedge core_clk_i);
        standby_req_valid_i <= 1'b0;
        watchdog_rst_i <= 1'b1;
        q_exp.push_back(2'h0);
        @(posedge core_clk_i);
        #1 chk(2'(sys_rst_o), 2'h1);
        @(posedge core_clk_i);
        watchdog_rst_i <= 1'b0;
        repeat (30) @(posedge core_clk_i);
        low_voltage_detector_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        #1 chk(2'(sys_rst_o), 2'h1);
        @(posedge core_clk_i);
        low_voltage_detector_i <= 1'b0;
        repeat (30) @(posedge core_clk_i);
        #1 chk(2'(q_exp.size()), 2'h0);
        summarize();
    end
endmodule : tb_top
